//--- co2_damper_ctrl.sv
// Baseline tracking, concentration estimate and damper decision with an AHB-Lite register file.
// Assumes the converter runs on hclk and delivers three 8-bit codes with a one-cycle valid.
//
// Overview of operation
// - Baseline is lowest gas code seen, meaning 400 ppm; lower reading replaces it.
// - Baseline unreplaced for idle period rises by the selected step.
// - Step pin low gives 20 ppm step, high gives 5 ppm step.
// - Period pin high gives 1 day idle period, low gives 7 days.
// - Only-stepped baseline unreplaced for reset period reloads from present gas reading.
// - Auto-reset pin high gives 7 days, low gives 30 days.
// - Analogue inputs arrive as 8-bit codes 0 to 255.
// - Setting code bands select open and close levels from the fixed table.
// - Concentration above open level drives damper output low.
// - Damper output returns high when concentration falls below close level or a fault is raised.
// - Damper output held high during warm-up and while fault is signalled.
// - Gas code on channel 0; larger code means more CO2.
// - Thermistor code on channel 1 corrects the concentration for temperature.
// - From 30 minutes after power-up, a thermistor drop raises heater fault.
// - Setting pins sampled once after reset; later changes ignored.
// - Thermistor at or below cold limit over 10 seconds means heater breakage.
`timescale 1ns/1ps
module co2_damper_ctrl #(
   parameter logic [31:0] SEC_CYCLES = co2_pkg::SEC_CYCLES,
   parameter logic [31:0] STEP_PERIOD_H_S = co2_pkg::STEP_PERIOD_H_S,
   parameter logic [31:0] STEP_PERIOD_L_S = co2_pkg::STEP_PERIOD_L_S,
   parameter logic [31:0] RESET_PERIOD_H_S = co2_pkg::RESET_PERIOD_H_S,
   parameter logic [31:0] RESET_PERIOD_L_S = co2_pkg::RESET_PERIOD_L_S,
   parameter logic [31:0] WARMUP_H_S = co2_pkg::WARMUP_H_S,
   parameter logic [31:0] WARMUP_L_S = co2_pkg::WARMUP_L_S,
   parameter logic [31:0] HEATER_WATCH_S = co2_pkg::HEATER_WATCH_S
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic adc_valid,
   input wire co2_pkg::adc_codes_t adc_codes,
   input wire logic warmup_select_pin,
   input wire logic step_size_select_pin,
   input wire logic step_period_select_pin,
   input wire logic auto_reset_period_select_pin,
   input wire logic manual_baseline_reset_input_n,
   output logic damper_request_output,
   output logic fault_output_n,
   output logic irq
);

   // ==========================================================
   // Pin synchronisers and one-time setting capture
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   logic man_prev_r;
   logic [1:0] settle_r;
   logic settings_valid_r;
   co2_pkg::pin_settings_t set_r;
   logic manual_ev;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_r <= 5'h1f;
         pin_s2_r <= 5'h1f;
         man_prev_r <= 1'b1;
      end else begin
         pin_s1_r <= {manual_baseline_reset_input_n, warmup_select_pin, step_size_select_pin,
                      step_period_select_pin, auto_reset_period_select_pin};
         pin_s2_r <= pin_s1_r;
         man_prev_r <= pin_s2_r[4];
      end
   end

   assign manual_ev = man_prev_r && !pin_s2_r[4];

   // Caught after release so the synchronisers hold real pin levels
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_r <= 2'h0;
         settings_valid_r <= 1'b0;
         set_r <= '0;
      end else if (!settings_valid_r) begin
         if (settle_r == co2_pkg::SETTLE_CYCLES) begin
            settings_valid_r <= 1'b1;
            set_r <= co2_pkg::pin_settings_t'(pin_s2_r[3:0]);
         end else begin
            settle_r <= settle_r + 2'h1;
         end
      end
   end

   // ==========================================================
   // Second tick and uptime
   logic [31:0] presc_r;
   logic sec_tick;
   logic [31:0] uptime_r;
   logic warm_done_r;
   logic [31:0] warmup_s;

   assign sec_tick = (presc_r == SEC_CYCLES - 32'd1);
   assign warmup_s = set_r.warmup_short ? WARMUP_H_S : WARMUP_L_S;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_r <= 32'h0;
         uptime_r <= 32'h0;
         warm_done_r <= 1'b0;
      end else begin
         presc_r <= sec_tick ? 32'h0 : presc_r + 32'd1;
         if (sec_tick && uptime_r != 32'hffff_ffff) begin
            uptime_r <= uptime_r + 32'd1;
         end
         if (settings_valid_r && uptime_r >= warmup_s) begin
            warm_done_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Converter samples
   logic [7:0] gas_r;
   logic [7:0] therm_r;
   logic [7:0] setting_r;
   logic gas_seen_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gas_r <= 8'h00;
         therm_r <= 8'hff;
         setting_r <= 8'h00;
         gas_seen_r <= 1'b0;
      end else if (adc_valid) begin
         gas_r <= adc_codes.gas;
         therm_r <= adc_codes.therm;
         setting_r <= adc_codes.setting;
         gas_seen_r <= 1'b1;
      end
   end

   // ==========================================================
   // Baseline tracking, fixed point with four fraction bits
   logic [11:0] baseline_r;
   logic [31:0] idle_s_r;
   logic [31:0] since_s_r;
   logic stepped_r;
   logic replace_ev;
   logic step_ev;
   logic reload_ev;
   logic [11:0] step_fx;
   logic [31:0] step_period_s;
   logic [31:0] reset_period_s;
   logic [12:0] stepped_sum;

   assign step_fx = set_r.step_small ? co2_pkg::STEP_H_FX : co2_pkg::STEP_L_FX;
   assign step_period_s = set_r.step_short ? STEP_PERIOD_H_S : STEP_PERIOD_L_S;
   assign reset_period_s = set_r.reset_short ? RESET_PERIOD_H_S : RESET_PERIOD_L_S;
   assign replace_ev = adc_valid && ({adc_codes.gas, 4'h0} < baseline_r);
   assign reload_ev = gas_seen_r && ((stepped_r && since_s_r >= reset_period_s)
                                     || manual_ev);
   assign step_ev = !replace_ev && !reload_ev && gas_seen_r
                    && idle_s_r >= step_period_s;
   assign stepped_sum = {1'b0, baseline_r} + {1'b0, step_fx};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         baseline_r <= co2_pkg::BASELINE_RESET;
         idle_s_r <= 32'h0;
         since_s_r <= 32'h0;
         stepped_r <= 1'b0;
      end else if (replace_ev) begin
         baseline_r <= {adc_codes.gas, 4'h0};
         idle_s_r <= 32'h0;
         since_s_r <= 32'h0;
         stepped_r <= 1'b0;
      end else if (reload_ev) begin
         baseline_r <= {gas_r, 4'h0};
         idle_s_r <= 32'h0;
         since_s_r <= 32'h0;
         stepped_r <= 1'b0;
      end else if (step_ev) begin
         // Saturate rather than wrap to a tiny baseline
         baseline_r <= stepped_sum[12] ? 12'hfff : stepped_sum[11:0];
         idle_s_r <= 32'h0;
         stepped_r <= 1'b1;
         if (sec_tick) begin
            since_s_r <= since_s_r + 32'd1;
         end
      end else if (sec_tick) begin
         idle_s_r <= idle_s_r + 32'd1;
         since_s_r <= since_s_r + 32'd1;
      end
   end

   // ==========================================================
   // Concentration estimate
   logic [7:0] gain_r;
   logic [7:0] cold_limit_r;
   logic [7:0] therm_ref_r;
   logic signed [13:0] delta;
   logic signed [9:0] temp_err;
   logic signed [14:0] comp;
   logic signed [23:0] prod;
   logic signed [24:0] ppm_sum;
   logic [15:0] ppm_r;

   always_comb begin
      delta = $signed({2'b00, gas_r, 4'h0}) - $signed({2'b00, baseline_r});
      temp_err = $signed({2'b00, therm_r}) - $signed({2'b00, therm_ref_r});
      comp = {delta[13], delta} - {{5{temp_err[9]}}, temp_err};
      prod = comp * $signed({1'b0, gain_r});
      ppm_sum = $signed({9'h000, co2_pkg::AMBIENT_PPM})
                + {prod[23], prod >>> co2_pkg::FRAC_BITS};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ppm_r <= co2_pkg::AMBIENT_PPM;
      end else if (ppm_sum[24]) begin
         ppm_r <= 16'h0000;
      end else if (|ppm_sum[23:16]) begin
         ppm_r <= 16'hffff;
      end else begin
         ppm_r <= ppm_sum[15:0];
      end
   end

   // ==========================================================
   // Heater watch
   logic [31:0] cold_s_r;
   logic fault_r;
   logic fault_ev;
   logic watch_on;

   assign watch_on = uptime_r >= HEATER_WATCH_S;
   assign fault_ev = !fault_r && watch_on
                     && cold_s_r > co2_pkg::HEATER_FAIL_TIME_S;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cold_s_r <= 32'h0;
         fault_r <= 1'b0;
      end else begin
         if (!watch_on || therm_r > cold_limit_r) begin
            cold_s_r <= 32'h0;
         end else if (sec_tick && cold_s_r != 32'hffff_ffff) begin
            cold_s_r <= cold_s_r + 32'd1;
         end
         // Held until reset; a dead heater does not heal
         if (fault_ev) begin
            fault_r <= 1'b1;
         end
      end
   end

   assign fault_output_n = !fault_r;

   // ==========================================================
   // Damper decision
   co2_pkg::levels_t lv;
   co2_pkg::damper_state_t damp_r;
   logic open_ev;
   logic close_ev;

   always_comb begin
      if (setting_r <= co2_pkg::SET_BAND0_MAX) begin
         lv = {co2_pkg::OPEN_PPM0, co2_pkg::CLOSE_PPM0};
      end else if (setting_r <= co2_pkg::SET_BAND1_MAX) begin
         lv = {co2_pkg::OPEN_PPM1, co2_pkg::CLOSE_PPM1};
      end else if (setting_r <= co2_pkg::SET_BAND2_MAX) begin
         lv = {co2_pkg::OPEN_PPM2, co2_pkg::CLOSE_PPM2};
      end else if (setting_r <= co2_pkg::SET_BAND3_MAX) begin
         lv = {co2_pkg::OPEN_PPM3, co2_pkg::CLOSE_PPM3};
      end else begin
         lv = {co2_pkg::OPEN_PPM4, co2_pkg::CLOSE_PPM4};
      end
   end

   assign open_ev = warm_done_r && !fault_r && damp_r == co2_pkg::DAMP_CLOSED
                    && ppm_r > lv.open_level;
   assign close_ev = damp_r == co2_pkg::DAMP_OPEN
                     && (!warm_done_r || fault_r || ppm_r < lv.close_level);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         damp_r <= co2_pkg::DAMP_CLOSED;
      end else begin
         unique case (damp_r)
            co2_pkg::DAMP_CLOSED: begin
               if (open_ev) begin
                  damp_r <= co2_pkg::DAMP_OPEN;
               end
            end
            co2_pkg::DAMP_OPEN: begin
               if (close_ev) begin
                  damp_r <= co2_pkg::DAMP_CLOSED;
               end
            end
            default: begin
               damp_r <= co2_pkg::DAMP_CLOSED;
            end
         endcase
      end
   end

   // High means close; the pin is the inverse of state bit 1
   assign damper_request_output = !damp_r[1];

   // ==========================================================
   // AHB-Lite slave, zero wait states
   logic ap_valid;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rd_mux;
   logic [co2_pkg::IRQ_W-1:0] irq_stat_r;
   logic [co2_pkg::IRQ_W-1:0] irq_mask_r;
   logic [co2_pkg::IRQ_W-1:0] irq_ev;
   logic [co2_pkg::IRQ_W-1:0] irq_clr;
   logic hit;

   assign ap_valid = hsel && htrans[1] && hready;
   assign hit = haddr[31:8] == 24'h0 && haddr[1:0] == 2'b00;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_comb begin
      rd_mux = 32'h0;
      if (hit) begin
         unique case (haddr[7:0])
            co2_pkg::OFS_STATUS: rd_mux = {20'h0, set_r, 4'h0, stepped_r, damp_r[1],
                                           fault_r, warm_done_r};
            co2_pkg::OFS_BASELINE: rd_mux = {20'h0, baseline_r};
            co2_pkg::OFS_PPM: rd_mux = {16'h0, ppm_r};
            co2_pkg::OFS_GAIN: rd_mux = {24'h0, gain_r};
            co2_pkg::OFS_LIMITS: rd_mux = {16'h0, therm_ref_r, cold_limit_r};
            co2_pkg::OFS_IRQ_STATUS: rd_mux = {26'h0, irq_stat_r};
            co2_pkg::OFS_IRQ_MASK: rd_mux = {26'h0, irq_mask_r};
            default: rd_mux = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         wr_pend_r <= ap_valid && hwrite && hit;
         wr_addr_r <= haddr[7:0];
         if (ap_valid && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gain_r <= co2_pkg::GAIN_RESET;
         cold_limit_r <= co2_pkg::COLD_LIMIT_RESET;
         therm_ref_r <= co2_pkg::THERM_REF_RESET;
         irq_mask_r <= '0;
      end else if (wr_pend_r) begin
         if (wr_addr_r == co2_pkg::OFS_GAIN) begin
            gain_r <= hwdata[7:0];
         end
         if (wr_addr_r == co2_pkg::OFS_LIMITS) begin
            cold_limit_r <= hwdata[7:0];
            therm_ref_r <= hwdata[15:8];
         end
         if (wr_addr_r == co2_pkg::OFS_IRQ_MASK) begin
            irq_mask_r <= hwdata[co2_pkg::IRQ_W-1:0];
         end
      end
   end

   // ==========================================================
   // Interrupts; a new event beats a same-cycle clear
   always_comb begin
      irq_ev = '0;
      irq_ev[co2_pkg::IRQ_REPLACE] = replace_ev;
      irq_ev[co2_pkg::IRQ_STEP] = step_ev;
      irq_ev[co2_pkg::IRQ_RELOAD] = reload_ev && !replace_ev;
      irq_ev[co2_pkg::IRQ_OPEN] = open_ev;
      irq_ev[co2_pkg::IRQ_CLOSE] = close_ev;
      irq_ev[co2_pkg::IRQ_FAULT] = fault_ev;
      irq_clr = '0;
      if (wr_pend_r && wr_addr_r == co2_pkg::OFS_IRQ_STATUS) begin
         irq_clr = hwdata[co2_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_r <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
         irq <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_mask_r);
      end
   end

endmodule : co2_damper_ctrl

//--- co2_damper_ctrl_assertions.sv
// Port checks for the CO2 baseline and damper block.
// Assumes the bind below hands on the shortened time parameters.
`timescale 1ns/1ps
module co2_damper_ctrl_checker #(
   parameter logic [31:0] SEC_CYCLES = 32'd4,
   parameter logic [31:0] WARMUP_H_S = 32'd2,
   parameter logic [31:0] HEATER_WATCH_S = 32'd3
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic adc_valid,
   input wire co2_pkg::adc_codes_t adc_codes,
   input wire logic damper_request_output,
   input wire logic fault_output_n,
   input wire logic irq
);
   // ==========================================================
   // Uptime and time since the last warm thermistor sample
   logic [31:0] up_r;
   logic [31:0] cold_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_r <= 32'h0;
      end else if (up_r != 32'hffffffff) begin
         up_r <= up_r + 32'h1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cold_r <= 32'h0;
      end else if (adc_valid && adc_codes.therm > 8'h60) begin
         cold_r <= 32'h0;
      end else if (cold_r != 32'hffffffff) begin
         cold_r <= cold_r + 32'h1;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   reset_outputs_a: assert property ($rose(hresetn) |-> damper_request_output && fault_output_n && !irq)
      else $error("outputs not at reset level");
   warmup_closed_a: assert property (up_r < WARMUP_H_S * SEC_CYCLES |-> damper_request_output)
      else $error("damper opened in warm-up");
   fault_closes_a: assert property (!fault_output_n [*3] |-> damper_request_output)
      else $error("damper open during fault");
   fault_sticky_a: assert property (!fault_output_n |=> !fault_output_n)
      else $error("fault released");
   watch_start_a: assert property (up_r < (HEATER_WATCH_S + 32'd10) * SEC_CYCLES |-> fault_output_n)
      else $error("fault before watch time");
   cold_time_a: assert property ($fell(fault_output_n) |-> cold_r >= 32'd10 * SEC_CYCLES)
      else $error("fault after short cold spell");
   open_cause_a: assert property ($fell(damper_request_output) |-> $past(adc_valid, 2) || $past(adc_valid, 3))
      else $error("damper opened without sample");
   close_cause_a: assert property ($rose(damper_request_output) |->
      $past(adc_valid, 2) || $past(adc_valid, 3) || !fault_output_n)
      else $error("damper closed without cause");
endmodule : co2_damper_ctrl_checker

bind co2_damper_ctrl co2_damper_ctrl_checker #(.SEC_CYCLES(SEC_CYCLES), .WARMUP_H_S(WARMUP_H_S),
   .HEATER_WATCH_S(HEATER_WATCH_S)) checker_i (.hclk(hclk), .hresetn(hresetn), .adc_valid(adc_valid),
   .adc_codes(adc_codes), .damper_request_output(damper_request_output),
   .fault_output_n(fault_output_n), .irq(irq));

//--- co2_front_end_model.sv
// Converter front end: presents gas, thermistor and setting codes every PERIOD cycles.
// Assumes the bench sets the analogue levels; codes are inverted outside the valid cycle.
`timescale 1ns/1ps
module co2_front_end_model #(
   parameter int PERIOD = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] gas,
   input wire logic [7:0] therm,
   input wire logic [7:0] setting,
   output logic adc_valid,
   output co2_pkg::adc_codes_t adc_codes
);
   // ==========================================================
   // Sampler
   int cnt;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         adc_valid <= 1'b0;
         adc_codes <= '1;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         adc_valid <= (cnt == PERIOD - 1);
         // Inverted outside valid so a stray capture cannot pass
         adc_codes <= (cnt == PERIOD - 1) ? {gas, therm, setting} : ~{gas, therm, setting};
      end
   end
endmodule : co2_front_end_model

//--- co2_pkg.sv
// Constants, field layouts and carrier types for the CO2 baseline and damper block.
// Assumes a single 40 MHz clock domain.
package co2_pkg;

   // ==========================================================
   // Timing
   localparam logic [31:0] CLK_HZ = 32'd40_000_000;
   localparam logic [31:0] SEC_TIME_S = 32'd1;
   localparam logic [31:0] SEC_CYCLES = CLK_HZ * SEC_TIME_S;
   localparam logic [31:0] MIN_S = 32'd60;
   localparam logic [31:0] DAY_S = 32'd86400;
   localparam logic [31:0] STEP_PERIOD_H_DAYS = 32'd1;
   localparam logic [31:0] STEP_PERIOD_L_DAYS = 32'd7;
   localparam logic [31:0] RESET_PERIOD_H_DAYS = 32'd7;
   localparam logic [31:0] RESET_PERIOD_L_DAYS = 32'd30;
   localparam logic [31:0] WARMUP_H_MIN = 32'd30;
   localparam logic [31:0] WARMUP_L_MIN = 32'd120;
   localparam logic [31:0] HEATER_WATCH_MIN = 32'd30;
   localparam logic [31:0] HEATER_FAIL_TIME_S = 32'd10;
   localparam logic [31:0] STEP_PERIOD_H_S = STEP_PERIOD_H_DAYS * DAY_S;
   localparam logic [31:0] STEP_PERIOD_L_S = STEP_PERIOD_L_DAYS * DAY_S;
   localparam logic [31:0] RESET_PERIOD_H_S = RESET_PERIOD_H_DAYS * DAY_S;
   localparam logic [31:0] RESET_PERIOD_L_S = RESET_PERIOD_L_DAYS * DAY_S;
   localparam logic [31:0] WARMUP_H_S = WARMUP_H_MIN * MIN_S;
   localparam logic [31:0] WARMUP_L_S = WARMUP_L_MIN * MIN_S;
   localparam logic [31:0] HEATER_WATCH_S = HEATER_WATCH_MIN * MIN_S;
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;

   // ==========================================================
   // Concentration arithmetic
   localparam int FRAC_BITS = 4;
   localparam logic [15:0] AMBIENT_PPM = 16'd400;
   localparam logic [7:0] GAIN_RESET = 8'h0a;
   localparam logic [15:0] STEP_L_PPM = 16'd20;
   localparam logic [15:0] STEP_H_PPM = 16'd5;
   localparam logic [11:0] STEP_L_FX = 12'((STEP_L_PPM * 16'd16) / 16'(GAIN_RESET));
   localparam logic [11:0] STEP_H_FX = 12'((STEP_H_PPM * 16'd16) / 16'(GAIN_RESET));
   localparam logic [11:0] BASELINE_RESET = 12'hfff;
   localparam logic [7:0] COLD_LIMIT_RESET = 8'h60;
   localparam logic [7:0] THERM_REF_RESET = 8'h80;

   // ==========================================================
   // Threshold table
   localparam logic [7:0] SET_BAND0_MAX = 8'd48;
   localparam logic [7:0] SET_BAND1_MAX = 8'd96;
   localparam logic [7:0] SET_BAND2_MAX = 8'd144;
   localparam logic [7:0] SET_BAND3_MAX = 8'd192;
   localparam logic [15:0] OPEN_PPM0 = 16'd800;
   localparam logic [15:0] CLOSE_PPM0 = 16'd720;
   localparam logic [15:0] OPEN_PPM1 = 16'd1000;
   localparam logic [15:0] CLOSE_PPM1 = 16'd800;
   localparam logic [15:0] OPEN_PPM2 = 16'd1500;
   localparam logic [15:0] CLOSE_PPM2 = 16'd1300;
   localparam logic [15:0] OPEN_PPM3 = 16'd2000;
   localparam logic [15:0] CLOSE_PPM3 = 16'd1800;
   localparam logic [15:0] OPEN_PPM4 = 16'd3000;
   localparam logic [15:0] CLOSE_PPM4 = 16'd2700;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_BASELINE = 8'h04;
   localparam logic [7:0] OFS_PPM = 8'h08;
   localparam logic [7:0] OFS_GAIN = 8'h0c;
   localparam logic [7:0] OFS_LIMITS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam int IRQ_W = 6;
   localparam int IRQ_REPLACE = 0;
   localparam int IRQ_STEP = 1;
   localparam int IRQ_RELOAD = 2;
   localparam int IRQ_OPEN = 3;
   localparam int IRQ_CLOSE = 4;
   localparam int IRQ_FAULT = 5;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [7:0] gas;
      logic [7:0] therm;
      logic [7:0] setting;
   } adc_codes_t;

   typedef struct packed {
      logic warmup_short;
      logic step_small;
      logic step_short;
      logic reset_short;
   } pin_settings_t;

   typedef struct packed {
      logic [15:0] open_level;
      logic [15:0] close_level;
   } levels_t;

   typedef enum logic [1:0] {
      DAMP_CLOSED = 2'b01,
      DAMP_OPEN = 2'b10
   } damper_state_t;

endpackage : co2_pkg

//--- test_co2_damper_ctrl.sv
// Self-checking bench for the CO2 baseline and damper block.
// Assumes shortened day and second parameters; one clock at 40 MHz.
`timescale 1ns/1ps
module test_co2_damper_ctrl;
   // ==========================================================
   // Signals and instances
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic [31:0] hrdata;
   logic adc_valid;
   co2_pkg::adc_codes_t adc_codes;
   logic [7:0] gas = 8'h05;
   logic [7:0] therm = 8'h80;
   logic [7:0] setting = 8'h30;
   co2_pkg::pin_settings_t pins = 4'hb;
   logic [2:0] hsize = 3'h2;
   logic man_n = 1'b1;
   localparam logic [31:0] ST_H = 32'd100, ST_L = 32'd110, RS_H = 32'd130, RS_L = 32'd140;
   logic damper;
   logic fault_n;
   logic irq;
   logic [31:0] rd;
   int fails = 0;
   int num_checks = 0;
   int n;
   int bmax[5] = '{48, 96, 144, 192, 255};
   int opn[5] = '{800, 1000, 1500, 2000, 3000};
   int cls[5] = '{720, 800, 1300, 1800, 2700};
   always #12.5 hclk = ~hclk;
   co2_front_end_model front_end (.clk(hclk), .rstn(hresetn), .gas(gas),
      .therm(therm), .setting(setting), .adc_valid(adc_valid), .adc_codes(adc_codes));
   co2_damper_ctrl #(.SEC_CYCLES(32'd4), .STEP_PERIOD_H_S(ST_H), .STEP_PERIOD_L_S(ST_L),
      .RESET_PERIOD_H_S(RS_H), .RESET_PERIOD_L_S(RS_L), .WARMUP_H_S(32'd2),
      .WARMUP_L_S(32'd3), .HEATER_WATCH_S(32'd3)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
      .adc_valid(adc_valid), .adc_codes(adc_codes), .warmup_select_pin(pins.warmup_short),
      .step_size_select_pin(pins.step_small), .step_period_select_pin(pins.step_short),
      .auto_reset_period_select_pin(pins.reset_short), .manual_baseline_reset_input_n(man_n),
      .damper_request_output(damper), .fault_output_n(fault_n), .irq(irq));
   // ==========================================================
   // Tasks
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk
   task automatic wait_ready;
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 20) begin
            fails++;
            end_of_test();
         end
         @(posedge hclk);
      end
   endtask : wait_ready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus
   // Pipeline settles inside 12 cycles
   task automatic set_gas(input int g, input logic exp);
      gas <= 8'(g);
      repeat (12) @(posedge hclk);
      chk("damper", {31'h0, exp}, {31'h0, damper});
   endtask : set_gas
   task automatic poll_base(input logic [31:0] old, input logic [31:0] exp);
      n = 0;
      do begin
         bus(1'b0, co2_pkg::OFS_BASELINE, 32'h0);
         n++;
      end while (rd === old && n < 400);
      chk("baseline", exp, rd);
      if (n >= 400) end_of_test();
   endtask : poll_base
   // ==========================================================
   // Sequence
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (20) @(posedge hclk);
      pins <= 4'h4;
      bus(1'b0, co2_pkg::OFS_STATUS, 32'h0);
      chk("status", 32'hb01, rd & 32'hf01);
      bus(1'b0, co2_pkg::OFS_BASELINE, 32'h0);
      chk("baseline", 32'h50, rd);
      set_gas(0, 1'b1);
      bus(1'b0, co2_pkg::OFS_BASELINE, 32'h0);
      chk("baseline", 32'h0, rd);
      bus(1'b0, co2_pkg::OFS_PPM, 32'h0);
      chk("ppm", 32'd400, rd);
      bus(1'b1, co2_pkg::OFS_GAIN, 32'h14);
      bus(1'b1, co2_pkg::OFS_IRQ_MASK, 32'h2);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      // Baseline 0, gain 20: 20 ppm per code
      for (int i = 0; i < 5; i++) begin
         setting <= 8'(bmax[i]);
         set_gas((opn[i] - 400) / 20, 1'b1);
         set_gas((opn[i] - 400) / 20 + 1, 1'b0);
         set_gas((cls[i] - 400) / 20, 1'b0);
         set_gas((cls[i] - 400) / 20 - 1, 1'b1);
      end
      setting <= 8'h00;
      set_gas(21, 1'b0);
      bus(1'b0, co2_pkg::OFS_PPM, 32'h0);
      chk("ppm", 32'd820, rd);
      therm <= 8'h82;
      repeat (12) @(posedge hclk);
      bus(1'b0, co2_pkg::OFS_PPM, 32'h0);
      chk("ppm", 32'd817, rd);
      set_gas(10, 1'b1);
      poll_base(32'h0, 32'h20);
      chk("irq", 32'h1, {31'h0, irq});
      poll_base(32'h20, 32'ha0);
      bus(1'b1, co2_pkg::OFS_IRQ_MASK, 32'h0);
      bus(1'b1, co2_pkg::OFS_IRQ_STATUS, 32'h3f);
      chk("irq", 32'h0, {31'h0, irq});
      bus(1'b0, co2_pkg::OFS_IRQ_STATUS, 32'h0);
      chk("irq status", 32'h0, rd);
      bus(1'b1, co2_pkg::OFS_IRQ_MASK, 32'h3f);
      set_gas(40, 1'b0);
      chk("irq", 32'h1, {31'h0, irq});
      therm <= 8'h50;
      n = 0;
      while (fault_n !== 1'b0 && n < 100) begin
         @(posedge hclk);
         n++;
      end
      chk("cold time", 32'h1, {31'h0, n >= 40 && n < 100});
      repeat (4) @(posedge hclk);
      chk("damper", 32'h1, {31'h0, damper});
      man_n <= 1'b0;
      poll_base(32'ha0, 32'h280);
      man_n <= 1'b1;
      gas <= 8'h0;
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (30) @(posedge hclk);
      chk("fault", 32'h1, {31'h0, fault_n});
      bus(1'b0, co2_pkg::OFS_STATUS, 32'h0);
      chk("status", 32'h401, rd & 32'hf01);
      gas <= 8'd40;
      poll_base(32'h0, 32'h8);
      poll_base(32'h8, 32'h280);
      end_of_test();
   end
endmodule : test_co2_damper_ctrl
